// [verilog/port_b_alternate_function_override.sv]
`timescale 1ns/1ps
module port_b_alternate_function_override (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // port register bits
  input wire logic [7:0] i_dir_reg,
  input wire logic [7:0] i_out_reg,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep_mode,
  // pads
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pullup_en,
  // serial peripheral interface
  input wire logic i_serial_if_enable,
  input wire logic i_serial_if_master_sel,
  input wire logic i_sck_out,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  output logic o_sck_in,
  output logic o_spi_master_in,
  output logic o_spi_slave_in,
  output logic o_spi_slave_select_n,
  output logic o_spi_slave_active,
  // timer compare outputs
  input wire logic i_timer3_cmp_b_out,
  input wire logic i_timer3_cmp_b_en,
  input wire logic i_timer3_cmp_a_out,
  input wire logic i_timer3_cmp_a_en,
  input wire logic i_timer0_cmp_b_out,
  input wire logic i_timer0_cmp_b_en,
  input wire logic i_timer0_cmp_a_out,
  input wire logic i_timer0_cmp_a_en,
  // timer count inputs
  output logic o_timer0_count_in,
  output logic o_timer1_count_in,
  // interrupt inputs
  input wire logic i_ext_irq_2_en,
  input wire logic [7:0] i_pin_change_mask,
  input wire logic i_pin_change_group1_en,
  output logic o_ext_irq_2,
  output logic [7:0] o_pin_change_src,
  // divided clock output
  input wire logic i_clk_out_fuse,
  input wire logic [3:0] i_clk_div_log2,
  // serial port 0 clock
  input wire logic i_serial0_sync_mode,
  input wire logic i_serial0_ext_clk_out,
  output logic o_serial0_ext_clk,
  // comparator
  output logic o_comparator_pos_in,
  output logic o_comparator_neg_in
);

  // ----------------------------------------------------------------
  // shared signals
  // ----------------------------------------------------------------

  pin_ovr_if ovr ();

  port_b_pkg::spi_role_t spi_role;
  logic divided_clk_out;
  logic [7:0] force_in;
  logic [7:0] pu_oe;
  logic [7:0] pu_val;
  logic [7:0] dd_oe;
  logic [7:0] dd_val;
  logic [7:0] pv_oe;
  logic [7:0] pv_val;
  logic [7:0] die_oe;
  logic [7:0] pin_change_keep;

  // ----------------------------------------------------------------
  // serial interface role
  // ----------------------------------------------------------------

  always_comb
  begin
    if (!i_serial_if_enable)
      spi_role = port_b_pkg::SPI_OFF;
    else if (i_serial_if_master_sel)
      spi_role = port_b_pkg::SPI_MASTER;
    else
      spi_role = port_b_pkg::SPI_SLAVE;
  end

  // pins each role turns into inputs
  always_comb
  begin
    force_in = port_b_pkg::PORT_RESET;
    unique case (spi_role)
      port_b_pkg::SPI_OFF:
      begin
        force_in = port_b_pkg::PORT_RESET;
      end
      port_b_pkg::SPI_SLAVE:
      begin
        force_in[port_b_pkg::PIN_SCK] = 1'b1;
        force_in[port_b_pkg::PIN_MOSI] = 1'b1;
        force_in[port_b_pkg::PIN_SS] = 1'b1;
      end
      port_b_pkg::SPI_MASTER:
      begin
        force_in[port_b_pkg::PIN_MISO] = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // divided clock
  // ----------------------------------------------------------------

  clk_out_divider u_divider (
    .i_clk(i_clk),
    .i_run(i_clk_out_fuse),
    .i_div_log2(i_clk_div_log2),
    .o_clk_out(divided_clk_out)
  );

  // ----------------------------------------------------------------
  // pull-up and direction overrides
  // ----------------------------------------------------------------

  // forced inputs keep their pull-up on the output register bit
  always_comb
  begin
    pu_oe = force_in;
    pu_val = force_in & i_out_reg & {8{~i_global_pullup_disable}};
  end

  always_comb
  begin
    dd_oe = force_in;
    dd_val = port_b_pkg::PORT_RESET;
    if (i_clk_out_fuse)
    begin
      dd_oe[port_b_pkg::PIN_DIV_CLK] = 1'b1;
      dd_val[port_b_pkg::PIN_DIV_CLK] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // value overrides, per pin
  // ----------------------------------------------------------------

  // pin 7: serial clock out as master, timer3 compare-B with the interface off
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_SCK] = 1'b0;
    pv_val[port_b_pkg::PIN_SCK] = 1'b0;
    if (spi_role == port_b_pkg::SPI_MASTER)
    begin
      pv_oe[port_b_pkg::PIN_SCK] = 1'b1;
      pv_val[port_b_pkg::PIN_SCK] = i_sck_out;
    end
    else if (spi_role == port_b_pkg::SPI_OFF && i_timer3_cmp_b_en
      && i_dir_reg[port_b_pkg::PIN_SCK])
    begin
      pv_oe[port_b_pkg::PIN_SCK] = 1'b1;
      pv_val[port_b_pkg::PIN_SCK] = i_timer3_cmp_b_out;
    end
  end

  // pin 6: slave data out as slave, timer3 compare-A with the interface off
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_MISO] = 1'b0;
    pv_val[port_b_pkg::PIN_MISO] = 1'b0;
    if (spi_role == port_b_pkg::SPI_SLAVE)
    begin
      pv_oe[port_b_pkg::PIN_MISO] = 1'b1;
      pv_val[port_b_pkg::PIN_MISO] = i_spi_slave_out;
    end
    else if (spi_role == port_b_pkg::SPI_OFF && i_timer3_cmp_a_en
      && i_dir_reg[port_b_pkg::PIN_MISO])
    begin
      pv_oe[port_b_pkg::PIN_MISO] = 1'b1;
      pv_val[port_b_pkg::PIN_MISO] = i_timer3_cmp_a_out;
    end
  end

  // pin 5: master data out as master
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_MOSI] = 1'b0;
    pv_val[port_b_pkg::PIN_MOSI] = 1'b0;
    if (spi_role == port_b_pkg::SPI_MASTER)
    begin
      pv_oe[port_b_pkg::PIN_MOSI] = 1'b1;
      pv_val[port_b_pkg::PIN_MOSI] = i_spi_master_out;
    end
  end

  // pin 4: timer0 compare-B unless the pin is a slave select input
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_SS] = 1'b0;
    pv_val[port_b_pkg::PIN_SS] = 1'b0;
    if (spi_role != port_b_pkg::SPI_SLAVE && i_timer0_cmp_b_en
      && i_dir_reg[port_b_pkg::PIN_SS])
    begin
      pv_oe[port_b_pkg::PIN_SS] = 1'b1;
      pv_val[port_b_pkg::PIN_SS] = i_timer0_cmp_b_out;
    end
  end

  // pin 3: timer0 compare-A
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_CMP0A] = 1'b0;
    pv_val[port_b_pkg::PIN_CMP0A] = 1'b0;
    if (i_timer0_cmp_a_en && i_dir_reg[port_b_pkg::PIN_CMP0A])
    begin
      pv_oe[port_b_pkg::PIN_CMP0A] = 1'b1;
      pv_val[port_b_pkg::PIN_CMP0A] = i_timer0_cmp_a_out;
    end
  end

  // pin 2: no alternate output, the port registers drive it
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_IRQ2] = 1'b0;
    pv_val[port_b_pkg::PIN_IRQ2] = 1'b0;
  end

  // pin 1: divided clock when the fuse is programmed
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_DIV_CLK] = i_clk_out_fuse;
    pv_val[port_b_pkg::PIN_DIV_CLK] = i_clk_out_fuse & divided_clk_out;
  end

  // pin 0: serial port clock out in synchronous mode with direction one
  always_comb
  begin
    pv_oe[port_b_pkg::PIN_XCK] = 1'b0;
    pv_val[port_b_pkg::PIN_XCK] = 1'b0;
    if (i_serial0_sync_mode && i_dir_reg[port_b_pkg::PIN_XCK])
    begin
      pv_oe[port_b_pkg::PIN_XCK] = 1'b1;
      pv_val[port_b_pkg::PIN_XCK] = i_serial0_ext_clk_out;
    end
  end

  // ----------------------------------------------------------------
  // digital input enable overrides
  // ----------------------------------------------------------------

  assign pin_change_keep = i_pin_change_mask & {8{i_pin_change_group1_en}};

  always_comb
  begin
    die_oe = pin_change_keep;
    die_oe[port_b_pkg::PIN_IRQ2] = pin_change_keep[port_b_pkg::PIN_IRQ2]
      | i_ext_irq_2_en;
  end

  // ----------------------------------------------------------------
  // override set onto the pads; in reset only the clock and the input enables stay
  // ----------------------------------------------------------------

  always_comb
  begin
    ovr.die_oe = die_oe;
    ovr.die_val = {8{1'b1}};
    if (i_reset_n)
    begin
      ovr.pu_oe = pu_oe;
      ovr.pu_val = pu_val;
      ovr.dd_oe = dd_oe;
      ovr.dd_val = dd_val;
      ovr.pv_oe = pv_oe;
      ovr.pv_val = pv_val;
    end
    else
    begin
      ovr.pu_oe = port_b_pkg::PORT_RESET;
      ovr.pu_val = port_b_pkg::PORT_RESET;
      ovr.dd_oe = dd_oe & (8'h01 << port_b_pkg::PIN_DIV_CLK);
      ovr.dd_val = dd_val & (8'h01 << port_b_pkg::PIN_DIV_CLK);
      ovr.pv_oe = pv_oe & (8'h01 << port_b_pkg::PIN_DIV_CLK);
      ovr.pv_val = pv_val & (8'h01 << port_b_pkg::PIN_DIV_CLK);
    end
  end

  pad_override u_pad (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .ovr(ovr.pad),
    .i_dir_reg(i_dir_reg),
    .i_out_reg(i_out_reg),
    .i_global_pullup_disable(i_global_pullup_disable),
    .i_sleep_mode(i_sleep_mode),
    .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .o_pullup_en(o_pullup_en)
  );

  // ----------------------------------------------------------------
  // inputs to the peripherals
  // ----------------------------------------------------------------

  // serial interface inputs
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_sck_in <= 1'b0;
      o_spi_master_in <= 1'b0;
      o_spi_slave_in <= 1'b0;
      o_spi_slave_select_n <= 1'b1;
      o_spi_slave_active <= 1'b0;
    end
    else
    begin
      o_sck_in <= ovr.din[port_b_pkg::PIN_SCK];
      o_spi_master_in <= ovr.din[port_b_pkg::PIN_MISO];
      o_spi_slave_in <= ovr.din[port_b_pkg::PIN_MOSI];
      o_spi_slave_select_n <= ovr.din[port_b_pkg::PIN_SS];
      o_spi_slave_active <= (spi_role == port_b_pkg::SPI_SLAVE)
        && !ovr.din[port_b_pkg::PIN_SS];
    end
  end

  // timer count sources and serial port clock
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_timer0_count_in <= 1'b0;
      o_timer1_count_in <= 1'b0;
      o_serial0_ext_clk <= 1'b0;
    end
    else
    begin
      o_timer0_count_in <= ovr.din[port_b_pkg::PIN_XCK];
      o_timer1_count_in <= ovr.din[port_b_pkg::PIN_DIV_CLK];
      o_serial0_ext_clk <= i_serial0_sync_mode
        && ovr.din[port_b_pkg::PIN_XCK];
    end
  end

  // interrupt sources
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_ext_irq_2 <= 1'b0;
      o_pin_change_src <= port_b_pkg::PORT_RESET;
    end
    else
    begin
      o_ext_irq_2 <= ovr.din[port_b_pkg::PIN_IRQ2];
      o_pin_change_src <= ovr.din;
    end
  end

  // ----------------------------------------------------------------
  // comparator taps, straight from the pads
  // ----------------------------------------------------------------

  assign o_comparator_neg_in = i_pin_in[port_b_pkg::PIN_CMP0A];
  assign o_comparator_pos_in = i_pin_in[port_b_pkg::PIN_IRQ2];

endmodule

// [include/port_b_pkg.sv]
package port_b_pkg;
  localparam int PORT_W = 8;
  localparam int PIN_SCK = 7;
  localparam int PIN_MISO = 6;
  localparam int PIN_MOSI = 5;
  localparam int PIN_SS = 4;
  localparam int PIN_CMP0A = 3;
  localparam int PIN_IRQ2 = 2;
  localparam int PIN_DIV_CLK = 1;
  localparam int PIN_XCK = 0;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int DIV_SEL_W = 4;
  localparam int DIV_CNT_W = 16;
  localparam logic [15:0] DIV_CNT_RESET = 16'h0000;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  typedef enum {SPI_OFF, SPI_SLAVE, SPI_MASTER} spi_role_t;
endpackage

// [include/pin_ovr_if.sv]
`timescale 1ns/1ps
interface pin_ovr_if;
  logic [7:0] pu_oe;
  logic [7:0] pu_val;
  logic [7:0] dd_oe;
  logic [7:0] dd_val;
  logic [7:0] pv_oe;
  logic [7:0] pv_val;
  logic [7:0] die_oe;
  logic [7:0] die_val;
  logic [7:0] din;
  modport src (
    output pu_oe, pu_val, dd_oe, dd_val, pv_oe, pv_val, die_oe, die_val,
    input din
  );
  modport pad (
    input pu_oe, pu_val, dd_oe, dd_val, pv_oe, pv_val, die_oe, die_val,
    output din
  );
endinterface

// [verilog/clk_out_divider.sv]
`timescale 1ns/1ps
module clk_out_divider (
  // clock
  input wire logic i_clk,
  // control
  input wire logic i_run,
  input wire logic [3:0] i_div_log2,
  // divided clock
  output logic o_clk_out
);
  logic [15:0] count_reg;
  logic [15:0] mask;
  logic tick;

  // one-cycle enable every 2^n cycles toggles the output
  assign mask = (port_b_pkg::DIV_ONE << i_div_log2) - port_b_pkg::DIV_ONE;
  assign tick = (count_reg & mask) == mask;

  // not cleared by chip reset so the clock keeps running through it
  always_ff @(posedge i_clk)
  begin
    if (!i_run)
    begin
      count_reg <= port_b_pkg::DIV_CNT_RESET;
      o_clk_out <= 1'b0;
    end
    else
    begin
      count_reg <= count_reg + port_b_pkg::DIV_ONE;
      if (tick)
        o_clk_out <= ~o_clk_out;
    end
  end
endmodule

// [verilog/pad_override.sv]
`timescale 1ns/1ps
module pad_override (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // override set from the alternate functions
  pin_ovr_if.pad ovr,
  // port register bits
  input wire logic [7:0] i_dir_reg,
  input wire logic [7:0] i_out_reg,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep_mode,
  // pads
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pullup_en
);
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] oe_next;
  logic [7:0] out_next;
  logic [7:0] pu_next;
  logic [7:0] din_en;

  assign oe_next = (ovr.dd_oe & ovr.dd_val) | (~ovr.dd_oe & i_dir_reg);
  assign out_next = (ovr.pv_oe & ovr.pv_val) | (~ovr.pv_oe & i_out_reg);
  assign pu_next = (ovr.pu_oe & ovr.pu_val)
    | (~ovr.pu_oe & ~i_dir_reg & i_out_reg & {8{~i_global_pullup_disable}});
  assign din_en = (ovr.die_oe & ovr.die_val) | (~ovr.die_oe & {8{~i_sleep_mode}});
  assign ovr.din = sync2_reg & din_en;

  always_ff @(posedge i_clk)
  begin
    sync1_reg <= i_pin_in;
    sync2_reg <= sync1_reg;
  end

  // reset keeps only the overrides still asserted, i.e. the clock output
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_pin_oe <= ovr.dd_oe & ovr.dd_val;
      o_pin_out <= ovr.pv_oe & ovr.pv_val;
      o_pullup_en <= port_b_pkg::PORT_RESET;
    end
    else
    begin
      o_pin_oe <= oe_next;
      o_pin_out <= out_next;
      o_pullup_en <= pu_next;
    end
  end
endmodule

// [verification/port_b_pad_model.sv]
`timescale 1ns/1ps
module port_b_pad_model (
  // clock
  input wire logic i_clk,
  // device side
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  input wire logic [7:0] i_pullup_en,
  // external drivers
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  // resolved pad level
  output logic [7:0] o_pad
);
  logic [7:0] last_reg = 8'h00;
  // remember only levels that something really drove
  always_ff @(posedge i_clk)
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (i_pin_oe[n] || i_ext_en[n] || i_pullup_en[n])
        last_reg[n] <= o_pad[n];
    end
  end
  // ----
  // pad resolution, a floating pad shows its inverted last level
  // ----
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (i_pin_oe[n])
        o_pad[n] = i_pin_out[n];
      else if (i_ext_en[n])
        o_pad[n] = i_ext_val[n];
      else if (i_pullup_en[n])
        o_pad[n] = 1'b1;
      else
        o_pad[n] = ~last_reg[n];
    end
  end
endmodule

// [verification/port_b_override_properties.sv]
`timescale 1ns/1ps
module port_b_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // watched inputs
  input wire logic [7:0] i_dir_reg,
  input wire logic [7:0] i_out_reg,
  input wire logic i_global_pullup_disable,
  input wire logic i_serial_if_enable,
  input wire logic i_serial_if_master_sel,
  input wire logic i_timer0_cmp_a_out,
  input wire logic i_timer0_cmp_a_en,
  input wire logic i_clk_out_fuse,
  input wire logic [7:0] i_pin_in,
  // watched outputs
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pullup_en,
  input wire logic o_comparator_pos_in,
  input wire logic o_comparator_neg_in
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_dir;
    $past(i_reset_n) |-> o_pin_oe[2] == $past(i_dir_reg[2]);
  endproperty
  a_dir: assert property (p_dir) else $error("pin 2 driver enable wrong");
  property p_val;
    $past(i_reset_n && i_dir_reg[2]) |-> o_pin_out[2] == $past(i_out_reg[2]);
  endproperty
  a_val: assert property (p_val) else $error("pin 2 level wrong");
  property p_slave_in;
    $past(i_reset_n && i_serial_if_enable && !i_serial_if_master_sel)
      |-> (o_pin_oe & 8'hB0) == 8'h00;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("slave pins driven");
  property p_master_in;
    $past(i_reset_n && i_serial_if_enable && i_serial_if_master_sel) |-> !o_pin_oe[6];
  endproperty
  a_master_in: assert property (p_master_in) else $error("pin 6 driven");
  property p_forced_pu;
    $past(i_reset_n && i_serial_if_enable && !i_serial_if_master_sel
      && !i_global_pullup_disable) |-> o_pullup_en[4] == $past(i_out_reg[4]);
  endproperty
  a_forced_pu: assert property (p_forced_pu) else $error("forced pull-up wrong");
  property p_cmp_a;
    $past(i_reset_n && i_dir_reg[3] && i_timer0_cmp_a_en)
      |-> o_pin_oe[3] && o_pin_out[3] == $past(i_timer0_cmp_a_out);
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("pin 3 compare output wrong");
  property p_clk_out;
    i_clk_out_fuse ##1 i_clk_out_fuse |-> o_pin_oe[1];
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("pin 1 not driven");
  property p_comp;
    1'b1 |-> o_comparator_pos_in == i_pin_in[2] && o_comparator_neg_in == i_pin_in[3];
  endproperty
  a_comp: assert property (p_comp) else $error("comparator inputs wrong");
endmodule
bind port_b_alternate_function_override port_b_checker chk_u (.i_clk, .i_reset_n,
  .i_dir_reg, .i_out_reg, .i_global_pullup_disable, .i_serial_if_enable,
  .i_serial_if_master_sel, .i_timer0_cmp_a_out, .i_timer0_cmp_a_en, .i_clk_out_fuse,
  .i_pin_in, .o_pin_out, .o_pin_oe, .o_pullup_en, .o_comparator_pos_in,
  .o_comparator_neg_in);

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_dir_reg = 8'h00, i_out_reg = 8'h00, i_pin_change_mask = 8'h00;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  logic i_global_pullup_disable = 1'b0, i_sleep_mode = 1'b0, i_serial_if_enable = 1'b0;
  logic i_serial_if_master_sel = 1'b0, i_sck_out = 1'b0, i_spi_slave_out = 1'b0;
  logic i_spi_master_out = 1'b0, i_timer3_cmp_b_out = 1'b0, i_timer3_cmp_b_en = 1'b0;
  logic i_timer3_cmp_a_out = 1'b0, i_timer3_cmp_a_en = 1'b0, i_timer0_cmp_b_out = 1'b0;
  logic i_timer0_cmp_b_en = 1'b0, i_timer0_cmp_a_out = 1'b0, i_timer0_cmp_a_en = 1'b0;
  logic i_ext_irq_2_en = 1'b0, i_pin_change_group1_en = 1'b0, i_clk_out_fuse = 1'b0;
  logic [3:0] i_clk_div_log2 = 4'h0;
  logic i_serial0_sync_mode = 1'b0, i_serial0_ext_clk_out = 1'b0;
  logic [7:0] i_pin_in, o_pin_out, o_pin_oe, o_pullup_en, o_pin_change_src;
  logic o_spi_slave_select_n, o_spi_slave_active, o_timer0_count_in, o_timer1_count_in;
  logic o_ext_irq_2, o_serial0_ext_clk, o_comparator_pos_in, o_comparator_neg_in;
  logic o_sck_in, o_spi_master_in, o_spi_slave_in;
  int fail_count = 0;
  int checks_done = 0;
  always #10 i_clk = ~i_clk;
  port_b_alternate_function_override dut_u (.i_clk, .i_reset_n, .i_dir_reg, .i_out_reg,
    .i_global_pullup_disable, .i_sleep_mode, .i_pin_in, .o_pin_out, .o_pin_oe,
    .o_pullup_en, .i_serial_if_enable, .i_serial_if_master_sel, .i_sck_out,
    .i_spi_slave_out, .i_spi_master_out, .o_sck_in, .o_spi_master_in,
    .o_spi_slave_in, .o_spi_slave_select_n, .o_spi_slave_active, .i_timer3_cmp_b_out,
    .i_timer3_cmp_b_en, .i_timer3_cmp_a_out, .i_timer3_cmp_a_en, .i_timer0_cmp_b_out,
    .i_timer0_cmp_b_en, .i_timer0_cmp_a_out, .i_timer0_cmp_a_en, .o_timer0_count_in,
    .o_timer1_count_in, .i_ext_irq_2_en, .i_pin_change_mask, .i_pin_change_group1_en,
    .o_ext_irq_2, .o_pin_change_src, .i_clk_out_fuse, .i_clk_div_log2,
    .i_serial0_sync_mode, .i_serial0_ext_clk_out, .o_serial0_ext_clk,
    .o_comparator_pos_in, .o_comparator_neg_in);
  port_b_pad_model pad_u (.i_clk, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pad(i_pin_in));
  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for the divided clock to change level
  task automatic wait_toggle();
    logic v;
    int k;
    v = o_pin_out[1];
    k = 0;
    while (o_pin_out[1] === v && k < 40)
    begin
      settle(1);
      k++;
    end
    checks_done++;
    if (k >= 40)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, v, ~v);
      wrap_up();
    end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    i_dir_reg <= 8'hF0;
    i_out_reg <= 8'hAA;
    settle(2);
    check(o_pin_oe, 8'hF0);
    check(o_pin_out & 8'hF0, 8'hA0);
    check(o_pullup_en, 8'h0A);
    @(posedge i_clk);
    i_global_pullup_disable <= 1'b1;
    settle(2);
    check(o_pullup_en, 8'h00);
    @(posedge i_clk);
    i_global_pullup_disable <= 1'b0;
    i_dir_reg <= 8'hFF;
    i_out_reg <= 8'hFF;
    i_serial_if_enable <= 1'b1;
    i_spi_slave_out <= 1'b1;
    i_timer0_cmp_b_en <= 1'b1;
    settle(2);
    check(o_pin_oe, 8'h4F);
    check(o_pullup_en, 8'hB0);
    check(o_pin_out & 8'h40, 8'h40);
    @(posedge i_clk);
    i_serial_if_master_sel <= 1'b1;
    i_sck_out <= 1'b1;
    i_spi_master_out <= 1'b1;
    settle(2);
    check(o_pin_oe, 8'hBF);
    check(o_pin_out & 8'hA0, 8'hA0);
    check(o_pullup_en, 8'h40);
    @(posedge i_clk);
    i_serial_if_enable <= 1'b0;
    i_out_reg <= 8'h00;
    {i_timer3_cmp_b_en, i_timer3_cmp_a_en, i_timer0_cmp_a_en} <= 3'h7;
    {i_timer3_cmp_b_out, i_timer3_cmp_a_out, i_timer0_cmp_b_out} <= 3'h5;
    i_timer0_cmp_a_out <= 1'b1;
    settle(2);
    check(o_pin_oe, 8'hFF);
    check(o_pin_out & 8'hD8, 8'h98);
    @(posedge i_clk);
    i_dir_reg <= 8'h01;
    i_serial0_sync_mode <= 1'b1;
    i_serial0_ext_clk_out <= 1'b1;
    settle(2);
    check(o_pin_oe, 8'h01);
    check(o_pin_out & 8'h01, 8'h01);
    @(posedge i_clk);
    i_dir_reg <= 8'h00;
    i_out_reg <= 8'hFF;
    i_clk_out_fuse <= 1'b1;
    i_clk_div_log2 <= 4'h1;
    settle(2);
    check(o_pin_oe, 8'h02);
    wait_toggle();
    wait_toggle();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    settle(2);
    check(o_pin_oe, 8'h02);
    check(o_pullup_en, 8'h00);
    check({7'h00, o_spi_slave_select_n}, 8'h01);
    wait_toggle();
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    i_clk_out_fuse <= 1'b0;
    i_out_reg <= 8'h00;
    i_serial_if_enable <= 1'b1;
    i_serial_if_master_sel <= 1'b0;
    i_pin_change_mask <= 8'hFF;
    i_pin_change_group1_en <= 1'b1;
    i_ext_irq_2_en <= 1'b1;
    ext_en <= 8'hFF;
    ext_val <= 8'hE7;
    settle(4);
    check(o_pin_change_src, 8'hE7);
    check({o_spi_slave_select_n, o_spi_slave_active, o_ext_irq_2, o_timer1_count_in,
      o_timer0_count_in, o_serial0_ext_clk, o_comparator_pos_in,
      o_comparator_neg_in}, 8'h7E);
    check({5'h00, o_sck_in, o_spi_master_in, o_spi_slave_in}, 8'h07);
    @(posedge i_clk);
    ext_val <= 8'h19;
    i_serial0_sync_mode <= 1'b0;
    settle(4);
    check(o_pin_change_src, 8'h19);
    check({o_spi_slave_select_n, o_spi_slave_active, o_ext_irq_2, o_timer1_count_in,
      o_timer0_count_in, o_serial0_ext_clk, o_comparator_pos_in,
      o_comparator_neg_in}, 8'h89);
    check({5'h00, o_sck_in, o_spi_master_in, o_spi_slave_in}, 8'h00);
    @(posedge i_clk);
    i_sleep_mode <= 1'b1;
    i_pin_change_group1_en <= 1'b0;
    ext_val <= 8'h1D;
    settle(4);
    check(o_pin_change_src, 8'h04);
    check({7'h00, o_ext_irq_2}, 8'h01);
    wrap_up();
  end
endmodule
